// file: logic/sep_top.sv
/*
  Serial EEPROM master port: two processor registers, a clock divider fed
  by the sampled instruction oscillator, an eight-bit full-duplex shifter
  and the mux that shares three general port pins with the serial lines.
  Assumes the oscillator and the serial input come from outside the mclk
  domain, and that software drives chip select on its own port pin.
*/
`timescale 1ns/1ps
module sep_top (
  input  wire logic       mclk,          // System clock, 200 MHz.
  input  wire logic       reset_n,       // Asynchronous reset, active low.
  input  wire logic       inst_osc,      // Instruction oscillator, unsynchronised.
  input  wire logic [7:0] reg_addr,      // Register address.
  input  wire logic       reg_wr,        // Write strobe, one cycle.
  input  wire logic       reg_rd,        // Read strobe, one cycle.
  input  wire logic [7:0] reg_wdata,     // Write data.
  output logic      [7:0] reg_rdata,     // Read data, one cycle after strobe.
  output logic            wr_ready,      // Data writes are accepted.
  output logic            xfer_busy,     // A byte is shifting or waiting in the buffer.
  input  wire logic [2:0] gpio_out,      // Port C output values for pins 0..2.
  input  wire logic [2:0] gpio_oe,       // Port C output enables for pins 0..2.
  input  wire logic [2:0] pin_in,        // Pin levels: 0 clock, 1 out, 2 in.
  output logic      [2:0] pin_out,       // Pin drive values.
  output logic      [2:0] pin_oe         // Pin drive enables, high drives.
);
  logic [7:0]            cfg_q;          // Configuration register.
  logic [7:0]            rx_q;           // Byte caught in the last transfer.
  logic [7:0]            shreg_q;        // Shift register.
  logic [3:0]            bits_q;         // Rising edges in this transfer.
  logic                  sclk_q;         // Serial clock.
  logic                  so_q;           // Serial data out.
  logic                  div_q;          // Half-rate toggle.
  logic [2:0]            osc_q;          // Oscillator sync stages and edge memory.
  logic [1:0]            si_q;           // Serial input sync stages.
  logic                  osc_edge;       // Either oscillator edge seen.
  logic                  tick;           // Serial clock may toggle now.
  logic                  dec_data;       // Address hits data register.
  logic                  dec_cfg;        // Address hits configuration register.
  logic                  last_fall;      // Final falling edge of a transfer.
  sep_pkg::sep_state_t   state_q;        // Shifter state.
  sep_stream_if #(.WIDTH(8)) wq ();      // Writes into the buffer.
  sep_stream_if #(.WIDTH(8)) sq ();      // Buffer out to the shifter.

  // Address decoding for the two registers.
  always_comb begin
    dec_data = 1'b0;
    dec_cfg  = 1'b0;
    if (reg_addr == sep_pkg::SEP_ADDR_DATA) begin
      dec_data = 1'b1;
    end else if (reg_addr == sep_pkg::SEP_ADDR_CFG) begin
      dec_cfg = 1'b1;
    end
  end

  // A data write is handed to the buffer and the processor carries on.
  assign wq.valid = reg_wr & dec_data;
  assign wq.data  = reg_wdata;
  assign sq.ready = (state_q == sep_pkg::SEP_IDLE);

  sep_buf2 #(.WIDTH(8)) u_buf (
    .mclk    (mclk),
    .reset_n (reset_n),
    .fill    (wq),
    .drain   (sq)
  );

  // Configuration: only enable, rate and test bits hold a value.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= sep_pkg::SEP_CFG_RESET;
    end else if (reg_wr && dec_cfg) begin
      cfg_q <= reg_wdata & sep_pkg::SEP_CFG_WMASK;
    end
  end

  // Read data is registered; reads never touch the shifter.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= sep_pkg::SEP_DATA_RESET;
    end else if (reg_rd && dec_data) begin
      reg_rdata <= rx_q;
    end else if (reg_rd && dec_cfg) begin
      reg_rdata <= cfg_q;
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
    end
  end

  // Write readiness and busy status, registered.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ready  <= 1'b0;
      xfer_busy <= 1'b0;
    end else begin
      wr_ready  <= wq.ready & ~wq.valid;
      xfer_busy <= (state_q == sep_pkg::SEP_SHIFT) | sq.valid;
    end
  end

  // Two flip-flops bring the oscillator and serial input into mclk.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      osc_q <= 3'h0;
      si_q  <= 2'h0;
    end else begin
      osc_q <= {osc_q[1:0], inst_osc};
      si_q  <= {si_q[0], pin_in[2]};
    end
  end

  // Each oscillator edge is a half period; normal mode uses every second one.
  assign osc_edge = osc_q[2] ^ osc_q[1];
  assign tick     = osc_edge & (cfg_q[sep_pkg::SEP_CFG_SPD] | div_q);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 1'b0;
    end else if (osc_edge) begin
      div_q <= ~div_q;
    end
  end

  assign last_fall = tick & sclk_q & (bits_q == sep_pkg::SEP_XFER_BITS);

  // Shifter: load starts a transfer, rise samples, fall presents next bit.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= sep_pkg::SEP_IDLE;
      shreg_q <= sep_pkg::SEP_DATA_RESET;
      rx_q    <= sep_pkg::SEP_DATA_RESET;
      bits_q  <= 4'h0;
      sclk_q  <= 1'b0;
      so_q    <= 1'b0;
    end else begin
      case (state_q)
        sep_pkg::SEP_IDLE: begin
          sclk_q <= 1'b0;
          if (sq.valid) begin
            shreg_q <= sq.data;
            so_q    <= sq.data[7];
            bits_q  <= 4'h0;
            state_q <= sep_pkg::SEP_SHIFT;
          end
        end
        sep_pkg::SEP_SHIFT: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              shreg_q <= {shreg_q[6:0], si_q[1]};
              bits_q  <= bits_q + 4'h1;
            end else if (last_fall) begin
              rx_q    <= shreg_q;
              state_q <= sep_pkg::SEP_IDLE;
            end else begin
              so_q <= shreg_q[7];
            end
          end
        end
        default: begin
          state_q <= sep_pkg::SEP_IDLE;
        end
      endcase
    end
  end

  // Pin sharing: serial lines take pins 0..2 only while enabled.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= 3'h0;
      pin_oe  <= 3'h0;
    end else if (cfg_q[sep_pkg::SEP_CFG_EN]) begin
      pin_out <= {1'b0, so_q, sclk_q};
      pin_oe  <= sep_pkg::SEP_OE_SERIAL;
    end else begin
      pin_out <= gpio_out;
      pin_oe  <= gpio_oe;
    end
  end

  // Checks on the clock rate, shifter, configuration reads and pin sharing.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // Helper for the rate check: an oscillator edge passed without a tick since
  // the last tick, and that last tick came at normal rate.
  logic skip_seen_q;  // An oscillator edge went by untaken.
  logic prev_norm_q;  // The previous tick came at normal rate.

  // Cleared by every tick, set by an untaken edge; no long repetition needed.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      skip_seen_q <= 1'b0;
      prev_norm_q <= 1'b0;
    end else if (tick) begin
      skip_seen_q <= 1'b0;
      prev_norm_q <= ~cfg_q[sep_pkg::SEP_CFG_SPD];
    end else if (osc_edge) begin
      skip_seen_q <= 1'b1;
    end
  end

  a_pin_serial_route : assert property ($past(reset_n) && $past(cfg_q[0]) |-> pin_oe == 3'h3 &&
    pin_out[1:0] == {$past(so_q), $past(sclk_q)}) else $error("serial pins misrouted");
  a_pin_gpio_route : assert property ($past(reset_n) && !$past(cfg_q[0]) |->
    pin_oe == $past(gpio_oe) &&
    pin_out == $past(gpio_out)) else $error("port pins misrouted");
  a_turbo_rate_tick : assert property (osc_edge && cfg_q[1] |-> tick)
    else $error("turbo missed an oscillator edge");
  a_normal_rate_skip : assert property (tick && !cfg_q[1] && prev_norm_q |-> skip_seen_q)
    else $error("normal rate ticked twice running");
  a_xfer_start_load : assert property (state_q == sep_pkg::SEP_IDLE && sq.valid |=>
    state_q == sep_pkg::SEP_SHIFT && so_q == $past(sq.data[7])) else $error("load failed");
  a_rx_capture_end : assert property (last_fall |=> rx_q == $past(shreg_q) &&
    $past(bits_q) == 4'h8) else $error("capture not eight bits");
  a_sclk_idle_low : assert property (state_q == sep_pkg::SEP_IDLE |-> !sclk_q)
    else $error("clock not low at idle");
  a_so_stable_high : assert property (sclk_q && $past(sclk_q) |-> $stable(so_q))
    else $error("data out moved while clock high");
  a_cfg_reserved_zero : assert property (reg_rd && dec_cfg |=> reg_rdata[7:5] == 3'h0 &&
    reg_rdata[3:2] == 2'h0) else $error("reserved bits read nonzero");
  a_read_no_start : assert property (reg_rd && !reg_wr && state_q == sep_pkg::SEP_IDLE &&
    !sq.valid |=> state_q == sep_pkg::SEP_IDLE) else $error("read started a transfer");

  c_turbo_xfer : cover property (cfg_q[1] && last_fall);
  c_normal_xfer : cover property (!cfg_q[1] && last_fall);
  c_buffer_full : cover property (!wq.ready && state_q == sep_pkg::SEP_SHIFT);
  c_write_while_busy : cover property (wq.valid && state_q == sep_pkg::SEP_SHIFT);
endmodule

// file: logic/sep_pkg.sv
/*
  Constants shared by the serial EEPROM port: register offsets in the
  peripheral register space, configuration field positions, reset values
  and the byte length of one transfer.
  Assumes a processor register port with an 8-bit address and 8-bit data.
*/
// Overview of operation
// - Enable bit routes shared pins to serial function.
// - Speed bit picks half or full oscillator rate.
// - Full duplex master, one bit in per bit out.
// - Data register write loads and starts transfer.
// - Data read returns last byte, no pin activity.
// - Transfers never stall the processor.
// - Hardware makes clock and data bits unaided.
// - Unused configuration bits ignore writes, read zero.
// - Test bit is held, software keeps it zero.
// - Reset clears all configuration bits to zero.
package sep_pkg;
  localparam logic [7:0] SEP_ADDR_DATA  = 8'h0C;  // Shift data register offset.
  localparam logic [7:0] SEP_ADDR_CFG   = 8'h0D;  // Configuration register offset.
  localparam int         SEP_CFG_EN     = 0;      // Pin enable bit position.
  localparam int         SEP_CFG_SPD    = 1;      // Rate select bit position.
  localparam int         SEP_CFG_TEST   = 4;      // Factory test bit position.
  localparam logic [7:0] SEP_CFG_WMASK  = 8'h13;  // Bits that hold written data.
  localparam logic [7:0] SEP_CFG_RESET  = 8'h00;  // Configuration after reset.
  localparam logic [7:0] SEP_DATA_RESET = 8'h00;  // Data registers after reset.
  localparam logic [3:0] SEP_XFER_BITS  = 4'h8;   // Bits in one transfer.
  localparam logic [2:0] SEP_OE_SERIAL  = 3'h3;   // Clock and data out driven, input free.
  typedef enum logic {SEP_IDLE, SEP_SHIFT} sep_state_t;  // Shifter states.
endpackage

// file: logic/sep_stream_if.sv
/*
  Valid/ready byte stream between the register front end, the two-entry
  buffer and the shifter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface sep_stream_if #(parameter int WIDTH = 8);
  logic             valid;  // Producer offers a word.
  logic             ready;  // Consumer can take a word.
  logic [WIDTH-1:0] data;   // The word on offer.
  modport src (output valid, output data, input ready);  // Producer side.
  modport snk (input valid, input data, output ready);   // Consumer side.
endinterface

// file: logic/sep_buf2.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module sep_buf2 #(
  parameter int WIDTH = 8   // Word width.
) (
  input  wire logic  mclk,     // System clock.
  input  wire logic  reset_n,  // Asynchronous reset, active low.
  sep_stream_if.snk  fill,     // Filling side.
  sep_stream_if.src  drain     // Draining side.
);
  logic [WIDTH-1:0] mem_q [2];  // The two storage slots.
  logic             wr_q;       // Next slot to write.
  logic             rd_q;       // Next slot to read.
  logic [1:0]       cnt_q;      // Words held.
  logic             push;       // A word enters.
  logic             pop;        // A word leaves.

  // Full and empty come straight from the word count register.
  assign fill.ready  = (cnt_q != 2'h2);
  assign drain.valid = (cnt_q != 2'h0);
  assign drain.data  = mem_q[rd_q];
  assign push        = fill.valid & fill.ready;
  assign pop         = drain.valid & drain.ready;

  // Storage is written only by an accepted word.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (push) begin
      mem_q[wr_q] <= fill.data;
    end
  end

  // Pointers and count track pushes and pops in the same cycle.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end

  a_buf_bound : assert property (@(posedge mclk) disable iff (!reset_n)
    cnt_q <= 2'h2) else $error("buffer count exceeds two");
endmodule

// file: tb/sep_eeprom_model.sv
/*
  Behavioural serial memory seen from its pins: takes in the master's bits
  and returns a preset byte. Assumes pin levels come from the mclk domain.
*/
`timescale 1ns/1ps
module sep_eeprom_model (
  input  wire logic       mclk,     // Bench clock, used to find edges.
  input  wire logic       cs_n,     // Chip select from a port pin, active low.
  input  wire logic       sclk,     // Serial clock from the master.
  input  wire logic       mosi,     // Master data out.
  input  wire logic [7:0] tx_byte,  // Byte returned in every frame.
  output logic            miso,     // Data back to the master.
  output logic      [7:0] rx_byte   // Last bits taken in.
);
  logic       sclk_q = 1'b0;  // Clock one sample back.
  logic [7:0] sh_q   = 8'h00; // Outgoing shifter.
  logic [3:0] cnt_q  = 4'h0;  // Bits taken in the current byte.
  logic       last_q = 1'b0;  // Last level driven while selected.
  // Take a bit on the rise, move on the fall, reload after eight bits.
  always @(posedge mclk) begin
    sclk_q <= sclk;
    if (cs_n) begin
      sh_q  <= tx_byte;
      cnt_q <= 4'h0;
    end else if (sclk && !sclk_q) begin
      rx_byte <= {rx_byte[6:0], mosi};
      cnt_q   <= cnt_q + 4'h1;
    end else if (!sclk && sclk_q) begin
      sh_q  <= (cnt_q == 4'h8) ? tx_byte : {sh_q[6:0], 1'b0};
      cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q;
    end
    if (!cs_n) last_q <= miso;
  end
  // A released line shows the inverse of its last level, never a stale copy.
  assign miso = cs_n ? ~last_q : sh_q[7];
endmodule

// file: tb/tb_top.sv
/*
  Self-checking bench for the serial memory port: register tasks, a clock
  edge monitor and one task per scenario. Assumes the model file above.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
  logic       mclk, reset_n, inst_osc, reg_wr, reg_rd, cs_n, miso;  // Scalars.
  logic       xfer_busy, wr_ready;                                  // Status.
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_byte, rx_byte, d;  // Bytes.
  logic [2:0] gpio_out, gpio_oe, pin_out, pin_oe;                   // Pins.
  int         fail_count, check_count, rises, hi_len, hi_max;       // Tallies.
  sep_top i_dut (.mclk, .reset_n, .inst_osc, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .wr_ready, .xfer_busy, .gpio_out, .gpio_oe, .pin_in({miso, pin_out[1:0]}),
    .pin_out, .pin_oe);
  sep_eeprom_model i_mem (.mclk, .cs_n, .sclk(pin_out[0]), .mosi(pin_out[1]), .tx_byte,
    .miso, .rx_byte);
  initial begin mclk = 0; forever #2.5 mclk = ~mclk; end
  // Oscillator runs free, out of phase with mclk.
  initial begin inst_osc = 0; #3.3; forever #62.5 inst_osc = ~inst_osc; end
  // Counts serial clock rises and the longest high phase.
  always @(posedge mclk) begin
    hi_len <= pin_out[0] ? hi_len + 1 : 0;
    if (pin_out[0] && hi_len == 0) rises <= rises + 1;
    if (pin_out[0] && hi_len + 1 > hi_max) hi_max <= hi_len + 1;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Register write; data writes wait for buffer room first.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    while (a == sep_pkg::SEP_ADDR_DATA && wr_ready !== 1'b1 && n < 4000) begin tick(1); n++; end
    if (n >= 4000) begin fail_count++; end_sim(); end
    reg_addr = a; reg_wdata = v; reg_wr = 1; tick(1); reg_wr = 0; tick(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr = a; reg_rd = 1; tick(1); reg_rd = 0; tick(1); v = reg_rdata;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (xfer_busy !== 1'b0 && n < 5000) begin tick(1); n++; end
    if (n >= 5000) begin fail_count++; end_sim(); end
  endtask
  task automatic t_reset;
    rd(sep_pkg::SEP_ADDR_CFG, d); `CHK("cfg reset", 8'h00, d)
    rd(sep_pkg::SEP_ADDR_DATA, d); `CHK("data reset", 8'h00, d)
    rd(8'h0E, d); `CHK("unmapped", 8'h00, d)
    gpio_oe = 3'h5; gpio_out = 3'h2; tick(2);
    `CHK("port oe", 3'h5, pin_oe)
    `CHK("port out", 3'h2, pin_out)
    $display("test reset done");
  endtask
  task automatic t_cfg;
    wr(sep_pkg::SEP_ADDR_CFG, 8'hFF); wr(8'h0E, 8'h00);
    rd(sep_pkg::SEP_ADDR_CFG, d); `CHK("cfg mask", 8'h13, d)
    wr(sep_pkg::SEP_ADDR_CFG, 8'h01); tick(1);
    `CHK("serial oe", 3'h3, pin_oe)
    `CHK("serial idle", 1'b0, pin_out[0])
    `CHK("serial in free", 1'b0, pin_out[2])
    $display("test config done");
  endtask
  // One byte at full rate, with the processor still served meanwhile.
  task automatic t_turbo;
    wr(sep_pkg::SEP_ADDR_CFG, 8'h03); tx_byte = 8'h3C; tick(1);
    cs_n = 0; rises = 0; hi_max = 0;
    wr(sep_pkg::SEP_ADDR_DATA, 8'hA5);
    `CHK("busy", 1'b1, xfer_busy)
    rd(sep_pkg::SEP_ADDR_CFG, d); `CHK("cfg in flight", 8'h03, d)
    wait_idle(); cs_n = 1;
    `CHK("mem got", 8'hA5, rx_byte)
    `CHK("rises", 8, rises)
    `CHK("turbo high", 1'b1, hi_max inside {[11:14]})
    rises = 0; rd(sep_pkg::SEP_ADDR_DATA, d); `CHK("rx", 8'h3C, d)
    rd(sep_pkg::SEP_ADDR_DATA, d); `CHK("quiet read", 0, rises)
    $display("test turbo done");
  endtask
  // Three bytes at half rate fill the buffer while the shifter is busy.
  task automatic t_normal;
    wr(sep_pkg::SEP_ADDR_CFG, 8'h01); tx_byte = 8'hC3; tick(1);
    cs_n = 0; rises = 0; hi_max = 0;
    wr(sep_pkg::SEP_ADDR_DATA, 8'h81); wr(sep_pkg::SEP_ADDR_DATA, 8'h7E);
    wr(sep_pkg::SEP_ADDR_DATA, 8'h5A);
    `CHK("buffer full", 1'b0, wr_ready)
    wait_idle(); cs_n = 1;
    `CHK("mem last", 8'h5A, rx_byte)
    `CHK("rises", 24, rises)
    `CHK("normal high", 1'b1, hi_max inside {[24:26]})
    rd(sep_pkg::SEP_ADDR_DATA, d); `CHK("rx", 8'hC3, d)
    wr(sep_pkg::SEP_ADDR_CFG, 8'h00); tick(1);
    `CHK("port back", 3'h5, pin_oe)
    $display("test normal done");
  endtask
  // A reset in mid-run clears a non-zero configuration and releases the pins.
  task automatic t_mid_reset;
    wr(sep_pkg::SEP_ADDR_CFG, 8'h13); gpio_oe = 3'h6; reset_n = 0; tick(2);
    `CHK("oe in reset", 3'h0, pin_oe)
    reset_n = 1; tick(2);
    rd(sep_pkg::SEP_ADDR_CFG, d); `CHK("cfg after reset", 8'h00, d)
    `CHK("port oe after reset", 3'h6, pin_oe)
    $display("test mid reset done");
  endtask
  initial begin
    reset_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0; gpio_out = 0;
    gpio_oe = 0; cs_n = 1; tx_byte = 0; fail_count = 0; check_count = 0;
    rises = 0; hi_len = 0; hi_max = 0;
    tick(2); reset_n = 1; tick(2);
    t_reset(); t_cfg(); t_turbo(); t_normal(); t_mid_reset();
    end_sim();
  end
endmodule
